/* rptg_pkg.sv */
// Purpose: Shared constants and types for the ramped pulse-train generator.
// Assumes: 100 MHz system clock, registers reached over a plain strobe port.
// Notes:   Offsets are byte addresses of 32-bit words.
package rptg_pkg;

	// Clock and timing.
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_HZ        = 100_000_000;
	localparam int NS_PER_MS     = 1_000_000;
	localparam int NS_PER_US     = 1_000;
	localparam int STEP_MS       = 10;
	localparam int STEP_CYCLES   = STEP_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int SCAN_US       = 10;
	localparam int SCAN_CYCLES   = SCAN_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int HALF_SUM      = CLK_HZ / 2;
	localparam int MS_PER_S      = 1000;

	// Setting limits.
	localparam logic [15:0] FREQ_MIN_M0 = 16'h0001;
	localparam logic [15:0] FREQ_MIN_M1 = 16'h0014;
	localparam logic [15:0] FREQ_MAX    = 16'h2710;
	localparam logic [16:0] M1_SCALE    = 17'h0000A;
	localparam logic [15:0] RAMP_MIN    = 16'h000A;
	localparam logic [15:0] RAMP_MAX    = 16'h2710;
	localparam logic [15:0] RAMP_UNIT   = 16'h000A;
	localparam logic [31:0] TARGET_MIN  = 32'h0000_0001;
	localparam logic [31:0] TARGET_MAX  = 32'h05F5_E100;

	// Error codes.
	localparam logic [15:0] ERR_NONE   = 16'h0000;
	localparam logic [15:0] ERR_START  = 16'h0002;
	localparam logic [15:0] ERR_TARGET = 16'h0003;
	localparam logic [15:0] ERR_STEADY = 16'h0004;
	localparam logic [15:0] ERR_RAMP   = 16'h0005;
	localparam logic [15:0] ERR_PULSES = 16'h0008;
	localparam logic [15:0] ERR_ORDER  = 16'h0009;

	// Register offsets.
	localparam logic [7:0] OFF_STEADY  = 8'h00;
	localparam logic [7:0] OFF_START   = 8'h04;
	localparam logic [7:0] OFF_RAMP    = 8'h08;
	localparam logic [7:0] OFF_DIR     = 8'h0C;
	localparam logic [7:0] OFF_TARGET  = 8'h10;
	localparam logic [7:0] OFF_EMITTED = 8'h14;
	localparam logic [7:0] OFF_ERROR   = 8'h18;
	localparam logic [7:0] OFF_CTRL    = 8'h1C;
	localparam logic [7:0] OFF_STATUS  = 8'h20;

	// Field positions.
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_DIR_LSB  = 1;
	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_DONE_BIT   = 1;
	localparam int ST_RAMP_BIT   = 2;
	localparam int ST_PERR_BIT   = 3;

	// Defaults loaded by the initialization input.
	localparam logic [15:0] DEF_STEADY = 16'h03E8;
	localparam logic [15:0] DEF_START  = 16'h0064;
	localparam logic [15:0] DEF_RAMP   = 16'h03E8;
	localparam logic [31:0] DEF_TARGET = 32'h0000_2710;

	typedef enum logic [1:0] {DIR_NONE, DIR_LEVEL, DIR_SPLIT} rptg_dir_e;

	typedef struct packed {
		logic [15:0] steady;
		logic [15:0] start;
		logic [15:0] ramp;
		logic [31:0] target;
		logic        opMode;
		rptg_dir_e   dirMode;
	} rptg_cfg_s;

endpackage

/* rptg_ramp.sv */
// Purpose: One ramped pulse-train channel with register port and status bits.
// Assumes: All inputs synchronous to clk; one channel per instance.
// Notes:   Summary of operation follows.
`timescale 1ns/1ps
module rptg_ramp #(
	parameter bit IS_SECOND   = 1'b0,
	parameter int STEP_CYCLES = rptg_pkg::STEP_CYCLES,
	parameter int SCAN_CYCLES = rptg_pkg::SCAN_CYCLES,
	parameter int CLK_HZ      = rptg_pkg::CLK_HZ
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	input  wire logic        execIn,
	input  wire logic        initDefaultsInput,
	input  wire logic        dirIn,
	output logic             pulsePortA,
	output logic             pulsePortB,
	output logic             dirPortC,
	output logic             completionOutput,
	output logic             busyBit,
	output logic             doneBit,
	output logic             rampingBit,
	output logic             programErrorFlag
);

	typedef enum {ST_IDLE, ST_ACCEL, ST_STEADY, ST_DECEL, ST_DONE} rptg_state_e;

	// Accumulator modulus: one wrap per half pulse period at the clock rate.
	localparam int HALF_SUM = CLK_HZ / 2;

	rptg_state_e         state_q;
	rptg_pkg::rptg_cfg_s cfg_q;
	rptg_pkg::rptg_cfg_s lat_q;
	logic        execPrev_q, execRise, dirStatus_q, latDir_q;
	logic [15:0] errCode_q, errCode_d;
	logic [31:0] pulseCnt_q, emitted_q, accelCnt_q;
	logic [26:0] acc_q, accSum;
	logic        lvl_q, pulsing, wrap, pulseEvt, lastPulse;
	logic [31:0] stepCnt_q, scanCnt_q;
	logic        stepTick, scanTick;
	logic [9:0]  k_q, nSteps;
	logic [16:0] fsHz, feHz, freqNow, latFs, latFe;
	logic [39:0] rampPulses, targetScaled;
	logic [26:0] rampProd;

	// Settings in hertz; mode 1 counts in 10 Hz units.
	function automatic logic [16:0] toHz(input logic [15:0] v, input logic mode);
		toHz = mode ? 17'(v * rptg_pkg::M1_SCALE) : {1'b0, v};
	endfunction

	// Frequency range per operation mode.
	function automatic logic freqOk(input logic [15:0] v, input logic mode);
		freqOk = (v >= (mode ? rptg_pkg::FREQ_MIN_M1 : rptg_pkg::FREQ_MIN_M0)) &&
			(v <= rptg_pkg::FREQ_MAX);
	endfunction

	assign execRise = execIn && !execPrev_q;
	assign fsHz     = toHz(cfg_q.start, cfg_q.opMode);
	assign feHz     = toHz(cfg_q.steady, cfg_q.opMode);
	assign latFs    = toHz(lat_q.start, lat_q.opMode);
	assign latFe    = toHz(lat_q.steady, lat_q.opMode);

	// Pulses used by both ramps versus the target, scaled to avoid division.
	assign rampPulses   = (40'(fsHz) + 40'(feHz)) *
		40'((cfg_q.ramp / rptg_pkg::RAMP_UNIT) * rptg_pkg::RAMP_UNIT);
	assign targetScaled = 40'(cfg_q.target) * 40'(rptg_pkg::MS_PER_S);

	// Settings check, lowest code first except order before pulse count.
	always_comb begin
		if (!freqOk(cfg_q.start, cfg_q.opMode)) begin
			errCode_d = rptg_pkg::ERR_START;
		end else if (cfg_q.target < rptg_pkg::TARGET_MIN || cfg_q.target > rptg_pkg::TARGET_MAX) begin
			errCode_d = rptg_pkg::ERR_TARGET;
		end else if (!freqOk(cfg_q.steady, cfg_q.opMode)) begin
			errCode_d = rptg_pkg::ERR_STEADY;
		end else if (cfg_q.ramp < rptg_pkg::RAMP_MIN || cfg_q.ramp > rptg_pkg::RAMP_MAX) begin
			errCode_d = rptg_pkg::ERR_RAMP;
		end else if (cfg_q.start >= cfg_q.steady) begin
			errCode_d = rptg_pkg::ERR_ORDER;
		end else if (rampPulses > targetScaled) begin
			errCode_d = rptg_pkg::ERR_PULSES;
		end else begin
			errCode_d = rptg_pkg::ERR_NONE;
		end
	end

	// Free-running scan timebase; step timebase held at zero in idle.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scanCnt_q <= 32'h0000_0000;
			stepCnt_q <= 32'h0000_0000;
		end else begin
			scanCnt_q <= scanTick ? 32'h0000_0000 : scanCnt_q + 32'h0000_0001;
			stepCnt_q <= (stepTick || state_q == ST_IDLE) ? 32'h0000_0000 : stepCnt_q + 32'h0000_0001;
		end
	end
	assign scanTick = scanCnt_q == 32'(SCAN_CYCLES - 1);
	assign stepTick = stepCnt_q == 32'(STEP_CYCLES - 1);

	// Setting words: software writes, defaults reload, read-only mirrors.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q <= '{rptg_pkg::DEF_STEADY, rptg_pkg::DEF_START, rptg_pkg::DEF_RAMP,
				rptg_pkg::DEF_TARGET, 1'b0, rptg_pkg::DIR_NONE};
		end else if (initDefaultsInput && !execIn && scanTick) begin
			cfg_q.steady <= rptg_pkg::DEF_STEADY;
			cfg_q.start  <= rptg_pkg::DEF_START;
			cfg_q.ramp   <= rptg_pkg::DEF_RAMP;
			cfg_q.target <= rptg_pkg::DEF_TARGET;
		end else if (regWr) begin
			unique case (regAddr)
				rptg_pkg::OFF_STEADY: cfg_q.steady <= regWdata[15:0];
				rptg_pkg::OFF_START:  cfg_q.start  <= regWdata[15:0];
				rptg_pkg::OFF_RAMP:   cfg_q.ramp   <= regWdata[15:0];
				rptg_pkg::OFF_TARGET: cfg_q.target <= regWdata;
				rptg_pkg::OFF_CTRL: begin
					cfg_q.opMode <= regWdata[rptg_pkg::CTRL_MODE_BIT];
					// The second channel has no split mode; it falls back to level mode.
					if (IS_SECOND && regWdata[rptg_pkg::CTRL_DIR_LSB +: 2] == 2'(rptg_pkg::DIR_SPLIT)) begin
						cfg_q.dirMode <= rptg_pkg::DIR_LEVEL;
					end else begin
						cfg_q.dirMode <= rptg_pkg::rptg_dir_e'(regWdata[rptg_pkg::CTRL_DIR_LSB +: 2]);
					end
				end
				default: ;
			endcase
		end
	end

	// Direction mirror and edge history.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dirStatus_q <= 1'b0;
			execPrev_q  <= 1'b0;
		end else begin
			dirStatus_q <= dirIn;
			execPrev_q  <= execIn;
		end
	end

	// Latch settings and validate on execution rise.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lat_q            <= '0;
			latDir_q         <= 1'b0;
			errCode_q        <= rptg_pkg::ERR_NONE;
			programErrorFlag <= 1'b0;
		end else begin
			if (execRise) begin
				lat_q     <= cfg_q;
				latDir_q  <= dirIn;
				errCode_q <= errCode_d;
			end
			// A new error wins over a same-cycle software clear.
			if (execRise && errCode_d != rptg_pkg::ERR_NONE) begin
				programErrorFlag <= 1'b1;
			end else if (regWr && regAddr == rptg_pkg::OFF_STATUS && regWdata[rptg_pkg::ST_PERR_BIT]) begin
				programErrorFlag <= 1'b0;
			end
		end
	end

	// Profile state machine.
	assign nSteps    = 10'(lat_q.ramp / rptg_pkg::RAMP_UNIT);
	assign lastPulse = pulseEvt && (pulseCnt_q + 32'h0000_0001 >= lat_q.target);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q    <= ST_IDLE;
			k_q        <= 10'h000;
			accelCnt_q <= 32'h0000_0000;
		end else if (!execIn) begin
			state_q <= ST_IDLE;
		end else if (execRise) begin
			state_q <= (errCode_d == rptg_pkg::ERR_NONE) ? ST_ACCEL : ST_IDLE;
			k_q     <= 10'h000;
		end else if (lastPulse) begin
			state_q <= ST_DONE;
		end else begin
			unique case (state_q)
				ST_ACCEL: if (stepTick) begin
					k_q <= k_q + 10'h001;
					if (k_q + 10'h001 >= nSteps) begin
						state_q    <= ST_STEADY;
						accelCnt_q <= pulseCnt_q;
					end
				end
				ST_STEADY: if (lat_q.target - pulseCnt_q <= accelCnt_q) begin
					state_q <= ST_DECEL;
				end
				ST_DECEL: if (stepTick && k_q != 10'h000) begin
					k_q <= k_q - 10'h001;
				end
				ST_IDLE, ST_DONE: ;
			endcase
		end
	end

	// Present frequency from the step index.
	assign rampProd = 27'(latFe - latFs) * 27'(k_q);
	assign freqNow  = latFs + 17'(rampProd / 27'(nSteps));

	// Phase accumulator: half period per wrap, a pulse per falling half.
	assign pulsing  = execIn && (state_q == ST_ACCEL || state_q == ST_STEADY || state_q == ST_DECEL);
	assign accSum   = acc_q + 27'(freqNow);
	assign wrap     = accSum >= 27'(HALF_SUM);
	assign pulseEvt = pulsing && wrap && lvl_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_q      <= 27'h0000000;
			lvl_q      <= 1'b0;
			pulseCnt_q <= 32'h0000_0000;
		end else begin
			if (!pulsing) begin
				acc_q <= 27'h0000000;
				lvl_q <= 1'b0;
			end else begin
				acc_q <= wrap ? accSum - 27'(HALF_SUM) : accSum;
				lvl_q <= lvl_q ^ wrap;
			end
			if (execRise) begin
				pulseCnt_q <= 32'h0000_0000;
			end else if (pulseEvt) begin
				pulseCnt_q <= pulseCnt_q + 32'h0000_0001;
			end
		end
	end

	// Emitted count word follows the counter once per scan.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			emitted_q <= 32'h0000_0000;
		end else if (scanTick) begin
			emitted_q <= pulseCnt_q;
		end
	end

	// Port routing and status bits.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pulsePortA       <= 1'b0;
			pulsePortB       <= 1'b0;
			dirPortC         <= 1'b0;
			busyBit          <= 1'b0;
			doneBit          <= 1'b0;
			rampingBit       <= 1'b0;
			completionOutput <= 1'b0;
		end else begin
			if (lat_q.dirMode == rptg_pkg::DIR_SPLIT && !IS_SECOND) begin
				pulsePortA <= pulsing && lvl_q && !latDir_q;
				pulsePortB <= pulsing && lvl_q && latDir_q;
			end else begin
				pulsePortA <= !IS_SECOND && pulsing && lvl_q;
				pulsePortB <= IS_SECOND && pulsing && lvl_q;
			end
			dirPortC   <= (lat_q.dirMode == rptg_pkg::DIR_LEVEL) && dirIn;
			busyBit    <= pulsing && !lastPulse;
			rampingBit <= pulsing && !lastPulse && (state_q == ST_ACCEL ||
				(state_q == ST_DECEL && k_q != 10'h000));
			if (execRise) begin
				doneBit <= 1'b0;
			end else if (lastPulse) begin
				doneBit <= 1'b1;
			end
			completionOutput <= execIn && (doneBit || lastPulse);
		end
	end

	// Register read port, data one cycle after the strobe.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdata <= 32'h0000_0000;
		end else if (regRd) begin
			unique case (regAddr)
				rptg_pkg::OFF_STEADY:  regRdata <= {16'h0000, cfg_q.steady};
				rptg_pkg::OFF_START:   regRdata <= {16'h0000, cfg_q.start};
				rptg_pkg::OFF_RAMP:    regRdata <= {16'h0000, cfg_q.ramp};
				rptg_pkg::OFF_DIR:     regRdata <= {31'h0000_0000, dirStatus_q};
				rptg_pkg::OFF_TARGET:  regRdata <= cfg_q.target;
				rptg_pkg::OFF_EMITTED: regRdata <= emitted_q;
				rptg_pkg::OFF_ERROR:   regRdata <= {16'h0000, errCode_q};
				rptg_pkg::OFF_CTRL:    regRdata <= {29'h0000_0000, 2'(cfg_q.dirMode), cfg_q.opMode};
				rptg_pkg::OFF_STATUS:  regRdata <= {28'h0000_000, programErrorFlag, rampingBit,
					doneBit, busyBit};
				default:               regRdata <= 32'h0000_0000;
			endcase
		end else begin
			regRdata <= 32'h0000_0000;
		end
	end

	// Checks.
	chk_busy_done_excl: assert property (@(posedge clk) disable iff (!arst_n) busyBit |-> !doneBit)
		else $error("busy and done both set");
	chk_ramp_in_busy: assert property (@(posedge clk) disable iff (!arst_n) rampingBit |-> busyBit)
		else $error("ramping without busy");
	chk_exec_fall_stop: assert property (@(posedge clk) disable iff (!arst_n)
		$fell(execIn) |=> !busyBit && !pulsePortA && !pulsePortB)
		else $error("pulsing continued after execution fell");
	chk_complete_gate: assert property (@(posedge clk) disable iff (!arst_n)
		!execIn |=> !completionOutput)
		else $error("completion high without execution");
	chk_done_count: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(doneBit) |-> pulseCnt_q == lat_q.target)
		else $error("done without reaching target");
	chk_start_error: assert property (@(posedge clk) disable iff (!arst_n)
		execRise && !freqOk(cfg_q.start, cfg_q.opMode) |=> errCode_q == rptg_pkg::ERR_START
		&& programErrorFlag)
		else $error("bad start frequency not flagged");
	chk_dir_readback: assert property (@(posedge clk) disable iff (!arst_n)
		regRd && regAddr == rptg_pkg::OFF_DIR |=> regRdata[0] == $past(dirIn, 2))
		else $error("direction word does not mirror input");
	chk_cfg_frozen: assert property (@(posedge clk) disable iff (!arst_n)
		execIn && !execRise |=> $stable(lat_q))
		else $error("latched settings changed during output");
	chk_init_ignored: assert property (@(posedge clk) disable iff (!arst_n)
		execIn && !regWr |=> $stable(cfg_q))
		else $error("settings reloaded while executing");
	chk_port_b_free: assert property (@(posedge clk) disable iff (!arst_n)
		!IS_SECOND && lat_q.dirMode != rptg_pkg::DIR_SPLIT |=> !pulsePortB)
		else $error("port B driven by first channel outside split mode");
	chk_level_dir: assert property (@(posedge clk) disable iff (!arst_n)
		lat_q.dirMode == rptg_pkg::DIR_LEVEL |=> dirPortC == $past(dirIn))
		else $error("port C does not follow direction in level mode");
	chk_dir_c_idle: assert property (@(posedge clk) disable iff (!arst_n)
		lat_q.dirMode != rptg_pkg::DIR_LEVEL |=> !dirPortC)
		else $error("port C driven outside level mode");
	chk_emitted_scan: assert property (@(posedge clk) disable iff (!arst_n)
		scanTick |=> emitted_q == $past(pulseCnt_q))
		else $error("emitted word not refreshed on scan tick");
	chk_err_on_rise: assert property (@(posedge clk) disable iff (!arst_n)
		execRise |=> errCode_q == $past(errCode_d))
		else $error("error word not written at execution rise");
	chk_restart_zero: assert property (@(posedge clk) disable iff (!arst_n)
		execRise |=> pulseCnt_q == 32'h0000_0000)
		else $error("pulse count not cleared at execution rise");
	chk_err_no_busy: assert property (@(posedge clk) disable iff (!arst_n)
		execRise && errCode_d != rptg_pkg::ERR_NONE |-> ##2 !busyBit)
		else $error("pulsing started with invalid settings");

	cov_done: cover property (@(posedge clk) disable iff (!arst_n) $rose(doneBit));
	cov_error: cover property (@(posedge clk) disable iff (!arst_n) $rose(programErrorFlag));
	cov_decel: cover property (@(posedge clk) disable iff (!arst_n) state_q == ST_DECEL);
	cov_abort: cover property (@(posedge clk) disable iff (!arst_n) busyBit && !execIn);
	cov_split: cover property (@(posedge clk) disable iff (!arst_n)
		pulsePortB && lat_q.dirMode == rptg_pkg::DIR_SPLIT);

endmodule

/* rptg_drv_model.sv */
// Purpose: Motor driver stand-in that counts step pulses on each input.
// Assumes: Step inputs are registered outputs of the generator.
// Notes:   Counts clear on request so each scenario starts from zero.
`timescale 1ns/1ps
module rptg_drv_model (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        clrCnt,
	input  wire logic        stepA,
	input  wire logic        stepB,
	output logic      [31:0] cntA_q,
	output logic      [31:0] cntB_q
);
	logic prevA_q;
	logic prevB_q;

	// Counts rising step edges, as the driver's opto input stage would.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prevA_q <= 1'b0;
			prevB_q <= 1'b0;
			cntA_q  <= 32'h0;
			cntB_q  <= 32'h0;
		end else begin
			prevA_q <= stepA;
			prevB_q <= stepB;
			if (clrCnt) begin
				cntA_q <= 32'h0;
				cntB_q <= 32'h0;
			end else begin
				cntA_q <= cntA_q + 32'(stepA && !prevA_q);
				cntB_q <= cntB_q + 32'(stepB && !prevB_q);
			end
		end
	end
endmodule

/* tb_rptg_ramp.sv */
// Purpose: Self-checking bench for one ramped pulse-train channel.
// Assumes: Short step and scan counts; register strobes one cycle long.
// Notes:   The timebase is scaled to 1 MHz so a completion run stays short.
`timescale 1ns/1ps
module tb_rptg_ramp;
	logic        clk      = 1'b0;
	logic        arst_n   = 1'b0;
	logic [7:0]  regAddr  = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic        regWr    = 1'b0;
	logic        regRd    = 1'b0;
	logic        execIn   = 1'b0;
	logic        initIn   = 1'b0;
	logic        dirIn    = 1'b0;
	logic        clrCnt   = 1'b0;
	logic [31:0] regRdata;
	logic        portA, portB, portC, complOut, busy, done, ramping, progErr;
	logic [31:0] cntA, cntB, rd, held;
	int          bad_count = 0;
	int          checks    = 0;

	rptg_ramp #(.IS_SECOND(1'b0), .STEP_CYCLES(50), .SCAN_CYCLES(10),
		.CLK_HZ(1_000_000)) i_dut (
		.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .execIn(execIn),
		.initDefaultsInput(initIn), .dirIn(dirIn), .pulsePortA(portA),
		.pulsePortB(portB), .dirPortC(portC), .completionOutput(complOut),
		.busyBit(busy), .doneBit(done), .rampingBit(ramping),
		.programErrorFlag(progErr));

	rptg_drv_model i_drv (.clk(clk), .arst_n(arst_n), .clrCnt(clrCnt), .stepA(portA),
		.stepB(portB), .cntA_q(cntA), .cntB_q(cntB));

	// Clock of 100 MHz.
	always #5 clk = ~clk;

	task automatic stop_test();
		if (bad_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmpBit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic chkReg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		cmp32(regRdata, exp);
	endtask

	task automatic setExec(input logic v);
		@(posedge clk);
		execIn <= v;
	endtask

	task automatic cfg(input logic m, input logic [1:0] dm, input logic [15:0] fe,
		input logic [15:0] fs, input logic [15:0] rt, input logic [31:0] tg);
		wr(rptg_pkg::OFF_STEADY, 32'(fe));
		wr(rptg_pkg::OFF_START, 32'(fs));
		wr(rptg_pkg::OFF_RAMP, 32'(rt));
		wr(rptg_pkg::OFF_TARGET, tg);
		wr(rptg_pkg::OFF_CTRL, {29'h0, dm, m});
		wr(rptg_pkg::OFF_STATUS, 32'h8);
	endtask

	task automatic t_regs();
		chkReg(rptg_pkg::OFF_STEADY, 32'(rptg_pkg::DEF_STEADY));
		chkReg(rptg_pkg::OFF_START, 32'(rptg_pkg::DEF_START));
		chkReg(rptg_pkg::OFF_RAMP, 32'(rptg_pkg::DEF_RAMP));
		chkReg(rptg_pkg::OFF_ERROR, 32'h0);
		chkReg(8'h24, 32'h0);
		@(posedge clk);
		dirIn <= 1'b1;
		wr(rptg_pkg::OFF_DIR, 32'h0);
		chkReg(rptg_pkg::OFF_DIR, 32'h1);
		wr(rptg_pkg::OFF_TARGET, 32'h05F5_E100);
		chkReg(rptg_pkg::OFF_TARGET, 32'h05F5_E100);
	endtask

	// One rise with the given settings, judged by code, flag and busy.
	task automatic errCase(input logic m, input logic [15:0] fe, input logic [15:0] fs,
		input logic [15:0] rt, input logic [31:0] tg, input logic [15:0] code);
		cfg(m, 2'h0, fe, fs, rt, tg);
		setExec(1'b1);
		cyc(4);
		cmpBit(progErr, code != 16'h0);
		cmpBit(busy, code == 16'h0);
		chkReg(rptg_pkg::OFF_ERROR, 32'(code));
		setExec(1'b0);
	endtask

	// Steady 1 kHz on the scaled timebase after one step; port use judged by the driver.
	task automatic t_run(input logic [1:0] dm, input logic dir, input logic onA);
		cfg(1'b0, dm, 16'h03E8, 16'h03E7, 16'h000A, 32'h0001_86A0);
		@(posedge clk);
		dirIn  <= dir;
		clrCnt <= 1'b1;
		@(posedge clk);
		clrCnt <= 1'b0;
		execIn <= 1'b1;
		cyc(4);
		cmpBit(busy, 1'b1);
		cmpBit(ramping, 1'b1);
		wr(rptg_pkg::OFF_TARGET, 32'h0);
		cyc(110);
		cmpBit(ramping, 1'b0);
		for (int i = 0; i < 4000 && (cntA + cntB) < 32'h3; i++) cyc(1);
		cmp32(cntA, onA ? 32'h3 : 32'h0);
		cmp32(cntB, onA ? 32'h0 : 32'h3);
		if (dm == rptg_pkg::DIR_LEVEL) cmpBit(portC, dir);
		cyc(530);
		chkReg(rptg_pkg::OFF_EMITTED, 32'h3);
		setExec(1'b0);
		cyc(4);
		cmpBit(busy, 1'b0);
		held = cntA + cntB;
		cyc(1200);
		cmp32(cntA + cntB, held);
		setExec(1'b1);
		cyc(4);
		chkReg(rptg_pkg::OFF_ERROR, 32'(rptg_pkg::ERR_TARGET));
		setExec(1'b0);
	endtask

	task automatic t_init();
		wr(rptg_pkg::OFF_STEADY, 32'h1234);
		@(posedge clk);
		execIn <= 1'b1;
		initIn <= 1'b1;
		cyc(30);
		chkReg(rptg_pkg::OFF_STEADY, 32'h1234);
		setExec(1'b0);
		cyc(30);
		chkReg(rptg_pkg::OFF_STEADY, 32'(rptg_pkg::DEF_STEADY));
		@(posedge clk);
		initIn <= 1'b0;
	endtask

	// One pulse at 98 Hz on the scaled timebase, about ten thousand cycles.
	task automatic t_done();
		cfg(1'b0, 2'h0, 16'h0062, 16'h0001, 16'h000A, 32'h1);
		@(posedge clk);
		clrCnt <= 1'b1;
		@(posedge clk);
		clrCnt <= 1'b0;
		execIn <= 1'b1;
		cyc(30);
		chkReg(rptg_pkg::OFF_EMITTED, 32'h0);
		for (int i = 0; i < 20000 && busy !== 1'b0; i++) cyc(1);
		cyc(2);
		cmpBit(done, 1'b1);
		cmpBit(complOut, 1'b1);
		cyc(2000);
		cmp32(cntA, 32'h1);
		chkReg(rptg_pkg::OFF_EMITTED, 32'h1);
		setExec(1'b0);
		cyc(3);
		cmpBit(complOut, 1'b0);
	endtask

	// Main sequence.
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		errCase(1'b0, 16'h03E8, 16'h0000, 16'h03E8, 32'h2710, 16'h0002);
		errCase(1'b1, 16'h03E8, 16'h0013, 16'h000A, 32'h2710, 16'h0002);
		errCase(1'b0, 16'h2711, 16'h0064, 16'h03E8, 32'h2710, 16'h0004);
		errCase(1'b0, 16'h03E8, 16'h0064, 16'h03E8, 32'h0, 16'h0003);
		errCase(1'b0, 16'h03E8, 16'h0064, 16'h03E8, 32'h05F5_E101, 16'h0003);
		errCase(1'b0, 16'h03E8, 16'h0064, 16'h0009, 32'h2710, 16'h0005);
		errCase(1'b0, 16'h03E8, 16'h0064, 16'h2711, 32'h2710, 16'h0005);
		errCase(1'b0, 16'h03E8, 16'h03E8, 16'h03E8, 32'h2710, 16'h0009);
		errCase(1'b0, 16'h03E8, 16'h0064, 16'h03E8, 32'h03E8, 16'h0008);
		errCase(1'b0, 16'h03E8, 16'h0064, 16'h03E8, 32'h044C, 16'h0000);
		t_run(rptg_pkg::DIR_NONE, 1'b0, 1'b1);
		t_run(rptg_pkg::DIR_LEVEL, 1'b1, 1'b1);
		t_run(rptg_pkg::DIR_SPLIT, 1'b0, 1'b1);
		t_run(rptg_pkg::DIR_SPLIT, 1'b1, 1'b0);
		t_init();
		t_done();
		stop_test();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		#800_000;
		bad_count++;
		$display("Error at %0t: run did not finish", $time);
		stop_test();
	end
endmodule
